// ==== logic/pfs_consts.vh ====
/*
 * Constants for the fast status summary block: management frame fields,
 * register addresses, bit positions, reset values, line symbols and timing.
 * Assumes an includer that uses these as plain text macros.
 */
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// Management register addresses
`define PFS_ADDR_STATUS 5'h01
`define PFS_ADDR_ID_HI 5'h02
`define PFS_ADDR_ID_LO 5'h03
`define PFS_ADDR_EXT_CTRL 5'h10
`define PFS_ADDR_SUMMARY 5'h11

// Management frame
`define PFS_PREAMBLE_BITS 6'h20
`define PFS_OP_READ 2'h2
`define PFS_OP_WRITE 2'h1
`define PFS_ADDR_BITS 6'h0a
`define PFS_TA_BITS 6'h02
`define PFS_DATA_BITS 6'h10

// Extended control register fields
`define PFS_EXT_OVERRIDE_BIT 15
`define PFS_EXT_PHYAD_LSB 6

// Summary register field positions
`define PFS_BIT_RATE 15
`define PFS_BIT_DUPLEX 14
`define PFS_BIT_SIG_ERR 10
`define PFS_BIT_LOCK_ERR 9
`define PFS_BIT_FALSE_CAR 8
`define PFS_BIT_INV_SYM 7
`define PFS_BIT_HALT_SYM 6
`define PFS_BIT_PREM_END 5
`define PFS_BIT_DUPLEX_SOURCE_PIN 2
`define PFS_BIT_REM_FAULT 1
`define PFS_BIT_LINK 0

// Reset values
`define PFS_RST_FLAGS 6'h00
`define PFS_RST_BIT 1'b0
`define PFS_RATE_100M 1'b1

// Line code groups, first received bit in the msb
`define PFS_SSD_JK 10'h311
`define PFS_SYM_IDLE 5'h1f
`define PFS_SYM_T 5'h0d
`define PFS_SYM_H 5'h04
`define PFS_SYM_LAST 3'h4

// Timing
`define PFS_CLK_KHZ 100000
`define PFS_TXCLK_KHZ 25000
`define PFS_TXDIV (`PFS_CLK_KHZ / `PFS_TXCLK_KHZ)

`endif

// ==== logic/pfs_sync2.v ====
/*
 * Two-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level or a clock far slower than clk;
 * bits are not coherent with each other.
 */
module pfs_sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q; // First stage, read only by the second
  reg [W-1:0] sync_q; // Second stage, safe to use

  // Both stages freeze with the enable so the group stays aligned
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else if (ce)
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // pfs_sync2

// ==== logic/pfs_status.v ====
/*
 * Fast status summary register with its management serial slave,
 * receive-symbol watcher and transmit clock divider.
 * Assumes rx_bit/rx_bit_stb, pll_locked, remote_fault, link_ok and
 * sw_duplex_mode come from logic on clk; pins are asynchronous.
 */
`include "pfs_consts.vh"
module pfs_status (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire mdc,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe,
  input wire [4:0] phy_addr,
  input wire duplex_source_pin,
  input wire duplex_select_pin,
  input wire sig_detect,
  input wire pll_locked,
  input wire rx_bit,
  input wire rx_bit_stb,
  input wire sw_duplex_mode,
  input wire remote_fault,
  input wire link_ok,
  output reg tx_clk,
  output reg full_duplex,
  output reg rx_in_frame,
  output reg rx_false_carrier,
  output reg rx_prem_end
);

  // Management frame states
  localparam S_PRE = 3'h0;
  localparam S_ST = 3'h1;
  localparam S_OP = 3'h2;
  localparam S_ADR = 3'h3;
  localparam S_TA = 3'h4;
  localparam S_DATA = 3'h5;

  // Pin synchronisation
  wire [9:0] pin_s; // Synchronised pin group
  wire mdc_s; // Management clock level
  wire mdio_s; // Management data level
  wire duplex_source_pin_s; // Duplex source pin
  wire duplex_select_pin_s; // Duplex select pin
  wire sig_s; // Signal present
  wire [4:0] phyad_s; // Strapped address
  pfs_sync2 #(.W(10)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({phy_addr, sig_detect, duplex_select_pin, duplex_source_pin, mdio_i, mdc}),
    .q(pin_s)
  );
  assign {phyad_s, sig_s, duplex_select_pin_s, duplex_source_pin_s, mdio_s, mdc_s} = pin_s;

  // Valid data or control code group check, used on every in-frame symbol
  function sym_ok;
    input [4:0] s;
    begin
      case (s)
        5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d,
        5'h1f, 5'h18, 5'h11, 5'h0d, 5'h07, 5'h04: sym_ok = 1'b1;
        default: sym_ok = 1'b0;
      endcase
    end
  endfunction

  reg mdc_prev_q; // Last synchronised management clock
  reg [2:0] st_q; // Frame state
  reg [5:0] cnt_q; // Bit counter within a field
  reg [1:0] op_q; // Operation code
  reg [9:0] adr_q; // Device and register address
  reg [15:0] sh_q; // Read or write data shifter
  reg ovr_q; // Write override from the extended control register
  reg [5:0] flag_q; // Latched error flags, bits 10 down to 5
  reg rf_q; // Latched-high remote fault
  reg link_q; // Latched-low link status
  reg [1:0] div_q; // Transmit clock divider
  reg [9:0] rx_sh_q; // Received bit window, oldest in msb
  reg [2:0] sym_cnt_q; // Bits of the current symbol
  reg sym_rdy_q; // A whole symbol sits in the window low bits
  reg prev_idle_q; // Previous in-frame symbol was idle
  reg [1:0] warm_q; // Enabled edges since reset, stops at two

  wire mdc_rise = mdc_s & ~mdc_prev_q; // Sampling edge of the management clock
  wire my_phy = (adr_q[9:5] == phyad_s);
  wire [4:0] reg_a = adr_q[4:0];
  wire is_rd = (op_q == `PFS_OP_READ);
  wire is_wr = (op_q == `PFS_OP_WRITE);
  wire adr_done = mdc_rise && (st_q == S_ADR) && (cnt_q == `PFS_ADDR_BITS - 6'h01);
  // adr_q[9:5] is still one bit short here, so the device match sits in the compare
  wire sum_read = adr_done && is_rd
    && ({adr_q[8:0], mdio_s} == {phyad_s, `PFS_ADDR_SUMMARY});
  wire wr_done = mdc_rise && (st_q == S_DATA) && (cnt_q == `PFS_DATA_BITS - 6'h01)
    && is_wr && my_phy;
  wire sum_write = wr_done && (reg_a == `PFS_ADDR_SUMMARY) && ovr_q;
  wire [4:0] rd_a = {adr_q[3:0], mdio_s}; // Register address incl. last bit

  // Receive events from the line and the recovery loop
  wire ev_sig = ~sig_s & warm_q[1];
  wire ev_lock = sig_s & ~pll_locked;
  wire zero_seen = !rx_in_frame && (rx_sh_q[9:8] == 2'b11) && !rx_sh_q[7];
  wire ssd_ok = (rx_sh_q == `PFS_SSD_JK);
  wire ev_fc = zero_seen && !ssd_ok && !(&rx_sh_q[5:0]);
  wire [4:0] sym = rx_sh_q[4:0];
  wire ev_prem = sym_rdy_q && rx_in_frame && (sym == `PFS_SYM_IDLE) && prev_idle_q;
  wire ev_halt = sym_rdy_q && rx_in_frame && (sym == `PFS_SYM_H);
  wire ev_inv = sym_rdy_q && rx_in_frame && !sym_ok(sym);
  wire [5:0] ev_vec = {ev_sig, ev_lock, ev_fc, ev_inv, ev_halt, ev_prem};

  // Summary word as seen by a read; reserved bits read zero
  wire [15:0] sum_word = {`PFS_RATE_100M, full_duplex, 3'h0, flag_q, 2'h0,
    duplex_source_pin_s, rf_q, link_q};

  // Read data for the addressed register; unmapped ones read zero
  reg [15:0] rd_val;
  always @*
  begin
    rd_val = 16'h0000;
    case (rd_a)
      `PFS_ADDR_SUMMARY: rd_val = sum_word;
      `PFS_ADDR_EXT_CTRL:
      begin
        rd_val[`PFS_EXT_OVERRIDE_BIT] = ovr_q;
        rd_val[`PFS_EXT_PHYAD_LSB+4:`PFS_EXT_PHYAD_LSB] = phyad_s;
      end
      default: rd_val = 16'h0000;
    endcase
  end

  // Management serial slave: frame decode, turnaround and data shifting.
  // Data changes just after the sampling edge so the master sees it settled.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdc_prev_q <= 1'b0;
      st_q <= S_PRE;
      cnt_q <= 6'h00;
      op_q <= 2'h0;
      adr_q <= 10'h000;
      sh_q <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      ovr_q <= 1'b0;
    end
    else if (ce)
    begin
      mdc_prev_q <= mdc_s;
      if (mdc_rise)
      begin
        case (st_q)
          S_PRE:
          begin
            // Count ones; a zero after enough of them is the start bit
            if (mdio_s)
            begin
              if (cnt_q != `PFS_PREAMBLE_BITS)
                cnt_q <= cnt_q + 6'h01;
            end
            else if (cnt_q == `PFS_PREAMBLE_BITS)
              st_q <= S_ST;
            else
              cnt_q <= 6'h00;
          end
          S_ST:
          begin
            // Second start bit must be one or the frame is dropped
            cnt_q <= 6'h00;
            st_q <= mdio_s ? S_OP : S_PRE;
          end
          S_OP:
          begin
            op_q <= {op_q[0], mdio_s};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h01)
            begin
              st_q <= S_ADR;
              cnt_q <= 6'h00;
            end
          end
          S_ADR:
          begin
            adr_q <= {adr_q[8:0], mdio_s};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == `PFS_ADDR_BITS - 6'h01)
            begin
              // Snapshot before latched bits clear this same cycle
              sh_q <= rd_val;
              st_q <= S_TA;
              cnt_q <= 6'h00;
            end
          end
          S_TA:
          begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h00)
            begin
              // Drive the turnaround zero only for our own reads
              mdio_oe <= is_rd && my_phy;
              mdio_o <= 1'b0;
            end
            else
            begin
              st_q <= S_DATA;
              cnt_q <= 6'h00;
              mdio_o <= sh_q[15];
              if (is_rd)
                sh_q <= {sh_q[14:0], 1'b0};
            end
          end
          S_DATA:
          begin
            cnt_q <= cnt_q + 6'h01;
            if (is_rd)
            begin
              mdio_o <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
            end
            else
              sh_q <= {sh_q[14:0], mdio_s};
            if (cnt_q == `PFS_DATA_BITS - 6'h01)
            begin
              mdio_oe <= 1'b0;
              mdio_o <= 1'b0;
              st_q <= S_PRE;
              cnt_q <= 6'h00;
            end
          end
          default:
          begin
            st_q <= S_PRE;
            cnt_q <= 6'h00;
          end
        endcase
      end
      // Override: extended control write sets it, a status-type write uses it up
      if (wr_done)
      begin
        if (reg_a == `PFS_ADDR_EXT_CTRL)
          ovr_q <= sh_q[14];
        else if (reg_a == `PFS_ADDR_STATUS || reg_a == `PFS_ADDR_ID_HI
          || reg_a == `PFS_ADDR_ID_LO || reg_a == `PFS_ADDR_SUMMARY)
          ovr_q <= 1'b0;
      end
    end
  end

  // Latched status bits. An event in the read cycle survives the clear.
  // An override write loads the latched fields from the written word.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= `PFS_RST_FLAGS;
      rf_q <= `PFS_RST_BIT;
      link_q <= `PFS_RST_BIT;
      full_duplex <= `PFS_RST_BIT;
    end
    else if (ce)
    begin
      if (sum_write)
      begin
        // Data bits 15..1 sit in sh_q[14:0]; bit 0 is still on the line
        flag_q <= sh_q[9:4] | ev_vec;
        rf_q <= sh_q[0] | remote_fault;
        link_q <= mdio_s & link_ok;
      end
      else
      begin
        flag_q <= (sum_read ? 6'h00 : flag_q) | ev_vec;
        rf_q <= (sum_read ? 1'b0 : rf_q) | remote_fault;
        link_q <= sum_read ? link_ok : (link_q & link_ok);
      end
      // Pin picks duplex unless priority hands it to software
      full_duplex <= duplex_source_pin_s ? sw_duplex_mode : duplex_select_pin_s;
    end
  end

  // Receive symbol watcher: start pair, false carrier, in-frame symbols
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sh_q <= 10'h3ff;
      rx_in_frame <= 1'b0;
      sym_cnt_q <= 3'h0;
      sym_rdy_q <= 1'b0;
      prev_idle_q <= 1'b0;
      rx_false_carrier <= 1'b0;
      rx_prem_end <= 1'b0;
    end
    else if (ce)
    begin
      sym_rdy_q <= 1'b0;
      rx_false_carrier <= ev_fc;
      rx_prem_end <= ev_prem;
      if (zero_seen)
      begin
        // Clearing the window stops the same zeros triggering twice
        rx_sh_q <= 10'h3ff;
        rx_in_frame <= ssd_ok;
        sym_cnt_q <= 3'h0;
        prev_idle_q <= 1'b0;
      end
      else if (rx_bit_stb)
      begin
        rx_sh_q <= {rx_sh_q[8:0], rx_bit};
        if (rx_in_frame)
        begin
          sym_cnt_q <= (sym_cnt_q == `PFS_SYM_LAST) ? 3'h0 : sym_cnt_q + 3'h1;
          sym_rdy_q <= (sym_cnt_q == `PFS_SYM_LAST);
        end
      end
      if (sym_rdy_q && rx_in_frame)
      begin
        prev_idle_q <= (sym == `PFS_SYM_IDLE);
        // Premature end or end delimiter returns to idle
        if (ev_prem || sym == `PFS_SYM_T)
          rx_in_frame <= 1'b0;
      end
      // Loss of signal aborts a frame in progress
      if (!sig_s)
        rx_in_frame <= 1'b0;
    end
  end

  // Transmit clock: divide by four, free running whenever enabled.
  // Warm-up count: the synchronisers leave reset at zero, which would read
  // as loss of signal, so loss events wait until the pin has come through.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 2'h0;
      tx_clk <= 1'b0;
      warm_q <= 2'h0;
    end
    else if (ce)
    begin
      if (!warm_q[1])
        warm_q <= warm_q + 2'h1;
      div_q <= (div_q == `PFS_TXDIV - 1) ? 2'h0 : div_q + 2'h1;
      tx_clk <= (div_q < `PFS_TXDIV / 2) ? 1'b1 : 1'b0;
    end
  end

endmodule // pfs_status

// ==== testbench/pfs_status_chk.sv ====
/*
 * Checker for the fast status summary block: transmit clock shape,
 * duplex source selection, management read framing and receive pulses.
 * Assumes one clock domain and that it sees only the top module's ports.
 */
module pfs_status_chk (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe,
  input wire duplex_source_pin,
  input wire duplex_select_pin,
  input wire sw_duplex_mode,
  input wire tx_clk,
  input wire full_duplex,
  input wire rx_in_frame,
  input wire rx_false_carrier,
  input wire rx_prem_end
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Management clock one cycle back, for edge counting
  logic mdc_q;
  // Management clock rises seen while the data line is driven
  logic [4:0] oe_rises_q;

  // Count rises during a read answer; a runaway driver shows as a count past 17
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdc_q <= 1'b0;
      oe_rises_q <= 5'h00;
    end
    else
    begin
      mdc_q <= mdc;
      if (!mdio_oe)
        oe_rises_q <= 5'h00;
      else if (mdc && !mdc_q)
        oe_rises_q <= oe_rises_q + 5'h01;
    end
  end

  // High phase and low phase of the transmit clock
  sequence s_tx_high;
    tx_clk [*2] ##1 !tx_clk;
  endsequence
  sequence s_tx_low;
    !tx_clk [*2] ##1 tx_clk;
  endsequence
  // Duplex inputs quiet long enough to pass the synchronisers
  sequence s_dup_still;
    ($stable(duplex_source_pin) && $stable(duplex_select_pin) && $stable(sw_duplex_mode)) [*4];
  endsequence

  // A low enable freezes the divider mid-phase, so phase checks stand down then
  a_txclk_high_two: assert property (disable iff (!rst_n || !ce)
    ce && $rose(tx_clk) |-> s_tx_high)
    else $error("transmit clock high phase wrong");
  a_txclk_low_two: assert property (disable iff (!rst_n || !ce)
    ce && $fell(tx_clk) |-> s_tx_low)
    else $error("transmit clock low phase wrong");
  a_duplex_source: assert property (s_dup_still |->
    full_duplex == (duplex_source_pin ? sw_duplex_mode : duplex_select_pin))
    else $error("duplex taken from the wrong source");
  a_oe_span_word: assert property ($fell(mdio_oe) |-> oe_rises_q == 5'd17)
    else $error("read answer not one full word");
  a_oe_cap_word: assert property (oe_rises_q <= 5'd17)
    else $error("data line driven too long");
  a_turn_zero: assert property ($rose(mdio_oe) |-> !mdio_o [*4])
    else $error("turnaround bit not zero");
  a_prem_leave_frame: assert property (rx_prem_end |-> ##[0:2] !rx_in_frame)
    else $error("receiver stays in frame after two idles");
  a_fc_out_frame: assert property (rx_false_carrier |-> !rx_in_frame)
    else $error("false carrier inside a frame");
  a_fc_one_pulse: assert property (rx_false_carrier |=> !rx_false_carrier)
    else $error("false carrier pulse too long");
endmodule // pfs_status_chk

bind pfs_status pfs_status_chk chk_u (
  .clk(clk), .rst_n(rst_n), .ce(ce), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
  .duplex_source_pin(duplex_source_pin), .duplex_select_pin(duplex_select_pin),
  .sw_duplex_mode(sw_duplex_mode), .tx_clk(tx_clk), .full_duplex(full_duplex),
  .rx_in_frame(rx_in_frame), .rx_false_carrier(rx_false_carrier), .rx_prem_end(rx_prem_end)
);

// ==== testbench/pfs_mgmt_model.sv ====
/*
 * Station management model: sends management frames on mdc and mdio.
 * Assumes the bench resolves mdio with a pull-up when nobody drives it.
 */
module pfs_mgmt_model (
  input wire logic clk,
  input wire logic mdio,
  output logic mdc,
  output logic m_oe,
  output logic m_d
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock stands low outside frames
  initial
  begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_d = 1'b0;
  end

  // One bit time of 80 ns; the line is sampled at the rising edge
  task automatic mbit(input logic drv, input logic b, output logic s);
    @(posedge clk);
    mdc <= 1'b0;
    m_oe <= drv;
    m_d <= b;
    repeat (4) @(posedge clk);
    s = mdio;
    mdc <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Whole frame: preamble, start, op, addresses, turnaround, word
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic [45:0] hdr;
    hdr = {32'hffffffff, 2'b01, op, pa, ra};
    for (int i = 45; i >= 0; i--)
      mbit(1'b1, hdr[i], s);
    // Turnaround: released on reads so the device can take the line
    mbit(op == 2'h1, 1'b1, s);
    mbit(op == 2'h1, 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      mbit(op == 2'h1, wd[i], s);
      rd[i] = s;
    end
    @(posedge clk);
    mdc <= 1'b0;
    m_oe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // pfs_mgmt_model

// ==== testbench/test_pfs_status.sv ====
/*
 * Testbench for the fast status summary block: table of pin and status cases,
 * then receive events, write protection, addressing and a second reset.
 * Assumes the design and its checker are compiled before this file.
 */
module test_pfs_status;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] PA = 5'h05;
  logic clk, rst_n, ce, rx_bit, rx_bit_stb;
  // Duplex source, duplex select, software duplex, signal, lock, fault, link
  logic dsrc, dsel, swd, sig, pll, rf, link;
  wire mdc, m_oe, m_d, mdio_o, mdio_oe, tx_clk, full_duplex;
  wire rx_in_frame, rx_false_carrier, rx_prem_end;
  // Pull-up wins when neither side drives
  wire mdio = mdio_oe ? mdio_o : (m_oe ? m_d : 1'b1);
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] n_fc = 16'h0000;
  logic [15:0] n_pe = 16'h0000;
  logic tx_hold; // Transmit clock level when the enable drops
  // Inputs in the top seven bits, expected word below
  logic [22:0] rows [4] = '{{7'b0101101, 16'hc001}, {7'b1100101, 16'h8405},
    {7'b1011011, 16'hc207}, {7'b0011100, 16'h8000}};

  pfs_status dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .mdc(mdc), .mdio_i(mdio),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr(PA), .duplex_source_pin(dsrc),
    .duplex_select_pin(dsel), .sig_detect(sig), .pll_locked(pll), .rx_bit(rx_bit),
    .rx_bit_stb(rx_bit_stb), .sw_duplex_mode(swd), .remote_fault(rf), .link_ok(link),
    .tx_clk(tx_clk), .full_duplex(full_duplex), .rx_in_frame(rx_in_frame),
    .rx_false_carrier(rx_false_carrier), .rx_prem_end(rx_prem_end));
  pfs_mgmt_model mm_u (.clk(clk), .mdio(mdio), .mdc(mdc), .m_oe(m_oe), .m_d(m_d));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] g;
    mm_u.frame(2'h2, pa, ra, 16'h0000, g);
    chk($sformatf("read %h", ra), e, g);
  endtask

  task wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] g;
    mm_u.frame(2'h1, PA, ra, d, g);
  endtask

  // Ten line bits, oldest first, one strobe every other cycle
  task rxw(input logic [9:0] w);
    for (int i = 9; i >= 0; i--)
    begin
      @(posedge clk);
      rx_bit <= w[i];
      rx_bit_stb <= 1'b1;
      @(posedge clk);
      rx_bit_stb <= 1'b0;
    end
  endtask

  // Pulse counters and the hang limit (about three times the expected run)
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rx_false_carrier === 1'b1)
      n_fc <= n_fc + 16'h0001;
    if (rx_prem_end === 1'b1)
      n_pe <= n_pe + 16'h0001;
    if (cyc == 30000)
    begin
      fails = fails + 1;
      wrap_up;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    {dsrc, dsel, swd, sig, pll, rf, link} = 7'b0001101;
    rx_bit = 1'b1;
    rx_bit_stb = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(PA, 5'h11, 16'h8000);
    $display("test reset value done");
    foreach (rows[i])
    begin
      @(posedge clk);
      {dsrc, dsel, swd, sig, pll, rf, link} <= rows[i][22:16];
      repeat (20) @(posedge clk);
      // Events gone again before the read: only the latches remember them
      {sig, pll, rf, link} <= 4'hd;
      repeat (10) @(posedge clk);
      rd(PA, 5'h11, rows[i][15:0]);
      rd(PA, 5'h11, (rows[i][15:0] & 16'hf81d) | 16'h0001);
      $display("test table row %0d done", i);
    end
    // Idles, start pair, halt and invalid symbols, two idles, then a false start
    rxw(10'h3ff);
    rxw(10'h311);
    rxw(10'h081);
    rxw(10'h3ff);
    rxw(10'h327);
    rxw(10'h3ff);
    rxw(10'h3ff);
    chk("premature end pulses", 16'h0001, n_pe);
    chk("false carrier pulses", 16'h0001, n_fc);
    rd(PA, 5'h11, 16'h81e1);
    $display("test receive events done");
    wr(5'h11, 16'h0400);
    rd(PA, 5'h11, 16'h8001);
    wr(5'h10, 16'h8000);
    // Written link bit one keeps the live link, so only bit 10 is new
    wr(5'h11, 16'h0401);
    rd(PA, 5'h11, 16'h8401);
    wr(5'h11, 16'h0200);
    rd(PA, 5'h11, 16'h8001);
    $display("test write override done");
    rd(5'h06, 5'h11, 16'hffff);
    rd(PA, 5'h05, 16'h0000);
    $display("test addressing done");
    // Enable low: every flop holds, so the transmit clock must stop
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    tx_hold = tx_clk;
    repeat (8) @(posedge clk);
    chk("frozen transmit clock", {15'h0000, tx_hold}, {15'h0000, tx_clk});
    ce <= 1'b1;
    $display("test clock enable done");
    // With the source pin high, duplex follows the software input, which the bench holds low across a second reset
    @(posedge clk);
    {dsrc, dsel, swd} <= 3'b110;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(PA, 5'h11, 16'h8004);
    $display("test second reset done");
    wrap_up;
  end
endmodule // test_pfs_status
